//--- common/timer_irq_dma_cfg.svh
`ifndef TIMER_IRQ_DMA_CFG_SVH
`define TIMER_IRQ_DMA_CFG_SVH

// hardware-fixed group priorities, placed in the vector low bits; GRP_FORCED is the second-byte DMA priority
`define GRP_OUF 3'h0
`define GRP_CAPT 3'h4
`define GRP_COMP 3'h6
`define GRP_FORCED 3'h0

// source index within pending, mask and event vectors
`define SRC_OUF 0
`define SRC_CAPT1 1
`define SRC_CAPT0 2
`define SRC_COMP1 3
`define SRC_COMP0 4
`define SRC_COUNT 5

// irq_dma_mask_reg bit positions
`define MSK_CAPT0_DMA 5
`define MSK_COMP0_DMA 6
`define MSK_GLOBAL 7
`define MSK_RESET 8'h00

// channel index for eob, toggle, overrun and dma pending bits
`define CH_CAPT0 0
`define CH_COMP0 1

// output action codes and field positions in an output control word
`define ACT_NOP 2'h0
`define ACT_SET 2'h1
`define ACT_CLR 2'h2
`define ACT_TGL 2'h3
`define OCF_COMP0 1:0
`define OCF_COMP1 3:2
`define OCF_OUF 5:4

`endif

//--- common/timer_irq_dma_pkg.sv
package timer_irq_dma_pkg;

  typedef enum logic [1:0] {
    DMA_IDLE,
    DMA_FIRST,
    DMA_SECOND
  } dma_phase_t;

  typedef struct packed {
    logic [7:0] mask;
    logic [4:0] pend;
    logic [1:0] overrun;
    logic [1:0] eob;
    logic [1:0] toggle;
    logic [1:0] dma_pend;
    dma_phase_t phase;
    logic chan;
    logic cnt_reset;
    logic irq_req;
    logic [7:0] vec;
  } irq_dma_state_t;

  typedef struct packed {
    logic pin;
  } out_ctrl_state_t;

endpackage

//--- design/output_ctrl.sv
// Purpose: one timer output pin driven by compare 0, compare 1 and over/underflow actions
// Assumes: events are one-cycle pulses on clk
// Notes: simultaneous events apply in order over/underflow, compare 0, compare 1
`timescale 1ns/1ps
`include "timer_irq_dma_cfg.svh"
module output_ctrl
  import timer_irq_dma_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [5:0] control,
  input wire logic preset_load,
  input wire logic preset_value,
  input wire logic compare0_event,
  input wire logic compare1_event,
  input wire logic over_underflow_event,
  output logic pin
);

  out_ctrl_state_t q, d;

  function automatic logic apply(input logic v, input logic ev, input logic [1:0] act);
    logic r;
    r = v;
    if (ev) begin
      case (act)
        `ACT_SET: r = 1'b1;
        `ACT_CLR: r = 1'b0;
        `ACT_TGL: r = ~v;
        default: r = v;
      endcase
    end
    return r;
  endfunction

  // R21: per-source action
  always_comb begin
    d = q;
    if (preset_load) begin
      d.pin = preset_value;
    end else begin
      d.pin = apply(d.pin, over_underflow_event, control[`OCF_OUF]);
      d.pin = apply(d.pin, compare0_event, control[`OCF_COMP0]);
      d.pin = apply(d.pin, compare1_event, control[`OCF_COMP1]);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pin = q.pin;

endmodule

//--- design/timer_irq_dma.sv
// Purpose: interrupt grouping, masking, overrun flags and two-channel DMA request logic of a timer
// Assumes: events come from logic on clk as one-cycle pulses; the DMA controller acks each byte
// Notes: software-side register writes arrive as strobes with data
// Notes on behaviour
// R1: five sources in three groups: compares x110, captures x100, over/underflow x000.
// R2: vector is five programmed high bits plus fixed three-bit group priority.
// R3: each source has its mask bit; mask bit 7 gates all timer interrupts.
// R4: compare0 or capture0 event while still pending sets its overrun flag.
// R5: two DMA channels; in DMA mode their interrupts come from end of block.
// R6: capture0 channel wins over compare0 channel when both request.
// R7: each DMA request has its own DMA mask; EOB interrupts own masks.
// R8: six upper pointer bits shared; each channel pair sits at adjacent addresses. Code shares five high bits; bit 2 is the channel toggle.
// R9: memory transfers: pointer address bit 1 low for capture0, high for compare0.
// R10: register transfers use one pointer pair; address pointer unused, reads zero.
// R11: word moves as two bytes; second byte forced to priority 000.
// R12: at end of table the counter is reset and end of block signalled.
// R13: in swap mode the channel toggle bit flips on each end of block.
// R14: toggle bits software readable and writable; each transfer uses its own.
// R15: one swap enable bit turns swap on for both channels.
// R16: EOB raises request at normal priority, held while DMA active, yields to over/underflow.
// R17: software EOB routine clears pending before re-enabling the DMA mask.
// R18: software may write EOB bits; a one with swap on raises an interrupt.
// R19: setting an EOB bit still set clears that channel's DMA mask.
// R20: output A toggled by over/underflow only; B set by compare0, cleared by compare1. Code makes both programmable by their output control words.
// R21: each output control lets each event nop, set, clear or toggle its pin.
// R22: with DMA mask on, compare0/capture0 raise DMA request held until word done.
`timescale 1ns/1ps
`include "timer_irq_dma_cfg.svh"
module timer_irq_dma
  import timer_irq_dma_pkg::*;
#(
  parameter int VEC_HI_W = 5,
  parameter int PTR_HI_W = 5
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic compare0_event,
  input wire logic compare1_event,
  input wire logic capture0_event,
  input wire logic capture1_event,
  input wire logic over_underflow_event,
  input wire logic [VEC_HI_W-1:0] vector_base_reg,
  input wire logic mask_wr,
  input wire logic [7:0] mask_wdata,
  input wire logic [4:0] pend_clr,
  input wire logic [1:0] overrun_clr,
  input wire logic eob_wr,
  input wire logic [1:0] eob_wdata,
  input wire logic toggle_wr,
  input wire logic [1:0] toggle_wdata,
  input wire logic swap_enable,
  input wire logic reg_to_reg_select,
  input wire logic [PTR_HI_W-1:0] counter_ptr_hi,
  input wire logic counter_ptr_bit1,
  input wire logic [PTR_HI_W-1:0] addr_ptr_hi,
  input wire logic dma_ack,
  input wire logic dma_block_end,
  input wire logic [5:0] output_a_control,
  input wire logic [5:0] output_b_control,
  input wire logic preset_load,
  input wire logic preset_a,
  input wire logic preset_b,
  output logic irq_req,
  output logic [7:0] irq_vector,
  output logic dma_req,
  output logic dma_chan,
  output logic dma_second_byte,
  output logic [2:0] dma_priority,
  output logic [7:0] dma_counter_ptr_addr,
  output logic [7:0] dma_addr_ptr_addr,
  output logic dma_counter_reset,
  output logic [7:0] irq_dma_mask_reg,
  output logic [4:0] pending,
  output logic [1:0] flag_reg,
  output logic [1:0] eob_flags,
  output logic [1:0] swap_toggles,
  output logic timer_output_a,
  output logic timer_output_b
);

  // the address and vector concatenations are laid out for five-bit high fields
  if (VEC_HI_W != 5 || PTR_HI_W != 5) begin : g_width_check
    $error("timer_irq_dma: vector and pointer high fields must be five bits wide");
  end

  irq_dma_state_t q, d;

  logic [4:0] ev;
  logic [4:0] act;
  logic [1:0] dma_mode;
  logic word_done;
  logic chan_tgl;

  assign ev = {compare0_event, compare1_event, capture0_event, capture1_event, over_underflow_event};
  // R7: DMA masks per channel
  assign dma_mode = {q.mask[`MSK_COMP0_DMA], q.mask[`MSK_CAPT0_DMA]};
  assign word_done = (q.phase == DMA_SECOND) && dma_ack;
  // R14: toggle of the serviced channel
  assign chan_tgl = q.toggle[q.chan];

  always_comb begin
    d = q;
    d.cnt_reset = 1'b0;

    // software writes first, hardware effects afterwards so hardware wins
    if (mask_wr) begin
      d.mask = mask_wdata;
    end
    d.pend = q.pend & ~pend_clr;
    d.overrun = q.overrun & ~overrun_clr;
    if (eob_wr) begin
      d.eob = eob_wdata;
      // R18: test write raises a request when swap is on
      if (swap_enable) begin
        if (eob_wdata[`CH_CAPT0]) begin
          d.pend[`SRC_CAPT0] = 1'b1;
        end
        if (eob_wdata[`CH_COMP0]) begin
          d.pend[`SRC_COMP0] = 1'b1;
        end
      end
    end
    if (toggle_wr) begin
      d.toggle = toggle_wdata;
    end

    // R1: non-DMA sources go straight to pending
    d.pend[`SRC_OUF] = d.pend[`SRC_OUF] | ev[`SRC_OUF];
    d.pend[`SRC_CAPT1] = d.pend[`SRC_CAPT1] | ev[`SRC_CAPT1];
    d.pend[`SRC_COMP1] = d.pend[`SRC_COMP1] | ev[`SRC_COMP1];

    // R4: overrun against the request still waiting
    if (ev[`SRC_CAPT0] && (dma_mode[`CH_CAPT0] ? q.dma_pend[`CH_CAPT0] : q.pend[`SRC_CAPT0])) begin
      d.overrun[`CH_CAPT0] = 1'b1;
    end
    if (ev[`SRC_COMP0] && (dma_mode[`CH_COMP0] ? q.dma_pend[`CH_COMP0] : q.pend[`SRC_COMP0])) begin
      d.overrun[`CH_COMP0] = 1'b1;
    end

    if (word_done) begin
      d.dma_pend[q.chan] = 1'b0;
    end
    // R22: DMA mode turns event into request
    if (ev[`SRC_CAPT0] && dma_mode[`CH_CAPT0]) begin
      d.dma_pend[`CH_CAPT0] = 1'b1;
    end else if (ev[`SRC_CAPT0]) begin
      d.pend[`SRC_CAPT0] = 1'b1;
    end
    if (ev[`SRC_COMP0] && dma_mode[`CH_COMP0]) begin
      d.dma_pend[`CH_COMP0] = 1'b1;
    end else if (ev[`SRC_COMP0]) begin
      d.pend[`SRC_COMP0] = 1'b1;
    end

    case (q.phase)
      DMA_IDLE: begin
        // R6: capture0 channel first
        if (q.dma_pend[`CH_CAPT0] && dma_mode[`CH_CAPT0]) begin
          d.chan = 1'b0;
          d.phase = DMA_FIRST;
        end else if (q.dma_pend[`CH_COMP0] && dma_mode[`CH_COMP0]) begin
          d.chan = 1'b1;
          d.phase = DMA_FIRST;
        end
      end
      DMA_FIRST: begin
        // R11: first byte taken, second follows at forced priority
        if (dma_ack) begin
          d.phase = DMA_SECOND;
        end
      end
      DMA_SECOND: begin
        if (dma_ack) begin
          d.phase = DMA_IDLE;
          // R12: end of table
          if (dma_block_end) begin
            d.cnt_reset = 1'b1;
            // R19: protection against an unserviced block
            if (q.eob[q.chan]) begin
              d.mask[q.chan ? `MSK_COMP0_DMA : `MSK_CAPT0_DMA] = 1'b0;
            end
            d.eob[q.chan] = 1'b1;
            // R5: block end drives the channel interrupt
            d.pend[q.chan ? `SRC_COMP0 : `SRC_CAPT0] = 1'b1;
            // R13: swap toggles the channel bit
            // R15: one enable for both channels
            if (swap_enable) begin
              d.toggle[q.chan] = ~q.toggle[q.chan];
            end
          end
        end
      end
      default: begin
        d.phase = DMA_IDLE;
      end
    endcase

    // R3: source masks and global enable
    act = q.pend & q.mask[4:0] & {`SRC_COUNT{q.mask[`MSK_GLOBAL]}};
    // R16: DMA channel interrupts wait while a DMA request is waiting or active
    if (q.phase != DMA_IDLE || (q.dma_pend & dma_mode) != 2'h0) begin
      act[`SRC_CAPT0] = act[`SRC_CAPT0] & ~dma_mode[`CH_CAPT0];
      act[`SRC_COMP0] = act[`SRC_COMP0] & ~dma_mode[`CH_COMP0];
    end
    // R2: vector from programmed high bits and fixed group
    d.irq_req = |act;
    if (act[`SRC_OUF]) begin
      d.vec = {vector_base_reg, `GRP_OUF};
    end else if (act[`SRC_CAPT0] || act[`SRC_CAPT1]) begin
      d.vec = {vector_base_reg, `GRP_CAPT};
    end else if (act[`SRC_COMP0] || act[`SRC_COMP1]) begin
      d.vec = {vector_base_reg, `GRP_COMP};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.mask <= `MSK_RESET;
      q.phase <= DMA_IDLE;
    end else begin
      q <= d;
    end
  end

  assign irq_req = q.irq_req;
  assign irq_vector = q.vec;
  assign dma_req = (q.phase != DMA_IDLE);
  assign dma_chan = q.chan;
  assign dma_second_byte = (q.phase == DMA_SECOND);
  // R11: forced top priority during the second byte
  assign dma_priority = (q.phase == DMA_SECOND) ? `GRP_FORCED : (q.chan ? `GRP_COMP : `GRP_CAPT);
  // R8: shared high bits, channel toggle, channel select bit
  // R9: bit 1 picks the channel for memory transfers
  assign dma_counter_ptr_addr = {counter_ptr_hi, chan_tgl,
                                 reg_to_reg_select ? counter_ptr_bit1 : q.chan, dma_second_byte};
  // R10: address pointer unused in register mode
  assign dma_addr_ptr_addr = reg_to_reg_select ? 8'h00 : {addr_ptr_hi, chan_tgl, q.chan, dma_second_byte};
  assign dma_counter_reset = q.cnt_reset;
  assign irq_dma_mask_reg = q.mask;
  assign pending = q.pend;
  assign flag_reg = q.overrun;
  assign eob_flags = q.eob;
  assign swap_toggles = q.toggle;

  // R20: output A and B action sets
  output_ctrl u_out_a (
    .clk(clk),
    .rst_b(rst_b),
    .control(output_a_control),
    .preset_load(preset_load),
    .preset_value(preset_a),
    .compare0_event(compare0_event),
    .compare1_event(compare1_event),
    .over_underflow_event(over_underflow_event),
    .pin(timer_output_a)
  );

  output_ctrl u_out_b (
    .clk(clk),
    .rst_b(rst_b),
    .control(output_b_control),
    .preset_load(preset_load),
    .preset_value(preset_b),
    .compare0_event(compare0_event),
    .compare1_event(compare1_event),
    .over_underflow_event(over_underflow_event),
    .pin(timer_output_b)
  );

  property p_vec_ouf;
    @(posedge clk) disable iff (!rst_b)
      (q.pend[`SRC_OUF] && q.mask[`SRC_OUF] && q.mask[`MSK_GLOBAL]) |=> (irq_vector[2:0] == `GRP_OUF);
  endproperty
  a_vec_ouf: assert property (p_vec_ouf) else $error("over/underflow not given top group"); // R1

  property p_vec_hi;
    @(posedge clk) disable iff (!rst_b)
      $rose(irq_req) |-> (irq_vector[7:3] == $past(vector_base_reg));
  endproperty
  a_vec_hi: assert property (p_vec_hi) else $error("vector high bits differ from base"); // R2

  property p_global;
    @(posedge clk) disable iff (!rst_b)
      !q.mask[`MSK_GLOBAL] |=> !irq_req;
  endproperty
  a_global: assert property (p_global) else $error("interrupt with global enable off"); // R3

  property p_overrun;
    @(posedge clk) disable iff (!rst_b)
      (capture0_event && !dma_mode[`CH_CAPT0] && q.pend[`SRC_CAPT0]) |=> flag_reg[`CH_CAPT0];
  endproperty
  a_overrun: assert property (p_overrun) else $error("capture0 overrun not flagged"); // R4

  property p_cap_first;
    @(posedge clk) disable iff (!rst_b)
      (q.phase == DMA_IDLE && q.dma_pend == 2'h3 && dma_mode == 2'h3) |=> (dma_req && !dma_chan);
  endproperty
  a_cap_first: assert property (p_cap_first) else $error("compare0 channel served before capture0"); // R6

  property p_second_prio;
    @(posedge clk) disable iff (!rst_b)
      (dma_req && !dma_second_byte && dma_ack) |=> (dma_priority == `GRP_FORCED && $stable(dma_chan));
  endproperty
  a_second_prio: assert property (p_second_prio) else $error("second byte not forced to top priority"); // R11

  property p_addr_bit1;
    @(posedge clk) disable iff (!rst_b)
      (dma_req && !reg_to_reg_select) |-> (dma_counter_ptr_addr[1] == dma_chan && dma_addr_ptr_addr[1] == dma_chan);
  endproperty
  a_addr_bit1: assert property (p_addr_bit1) else $error("pointer bit 1 does not follow channel"); // R9

  property p_swap;
    @(posedge clk) disable iff (!rst_b)
      (word_done && dma_block_end && swap_enable && !toggle_wr) |=> (swap_toggles[$past(q.chan)] != $past(chan_tgl));
  endproperty
  a_swap: assert property (p_swap) else $error("toggle bit not flipped at block end"); // R13

  property p_protect;
    @(posedge clk) disable iff (!rst_b)
      (word_done && dma_block_end && q.eob[q.chan] && q.chan) |=> !irq_dma_mask_reg[`MSK_COMP0_DMA];
  endproperty
  a_protect: assert property (p_protect) else $error("dma mask kept after repeated block end"); // R19

  property p_eob_reset;
    @(posedge clk) disable iff (!rst_b)
      (word_done && dma_block_end) |=> (dma_counter_reset ##1 !dma_counter_reset);
  endproperty
  a_eob_reset: assert property (p_eob_reset) else $error("counter reset not a single pulse"); // R12

endmodule

//--- tb/dma_ctrl_model.sv
// Purpose: DMA controller stand-in that acks each byte the timer requests
// Assumes: request signals change only after rising edges
// Notes: block end means something only beside the second-byte ack
`timescale 1ns/1ps
module dma_ctrl_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic dma_req,
  input wire logic dma_second_byte,
  input wire logic [3:0] delay,
  input wire logic end_block,
  output logic dma_ack,
  output logic dma_block_end
);
  logic [3:0] wait_q;
  always @(negedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dma_ack <= 1'b0;
      dma_block_end <= 1'b0;
      wait_q <= 4'h0;
    end else begin
      dma_ack <= 1'b0;
      // unqualified line wanders
      dma_block_end <= ~dma_block_end;
      wait_q <= 4'h0;
      if (dma_req && !dma_ack && wait_q < delay) begin
        wait_q <= wait_q + 4'h1;
      end else if (dma_req && !dma_ack) begin
        dma_ack <= 1'b1;
        dma_block_end <= end_block & dma_second_byte;
      end
    end
  end
endmodule

//--- tb/tb_timer_irq_dma.sv
// Purpose: self-checking bench for timer interrupt grouping, overruns and DMA requests
// Assumes: inputs change on falling edges, outputs sampled on falling edges
// Notes: software writes are one-cycle strobes
`timescale 1ns/1ps
module tb_timer_irq_dma;
  import timer_irq_dma_pkg::*;
  localparam logic [4:0] VB = 5'h15;
  localparam logic [4:0] CP = 5'h0a;
  localparam logic [4:0] AP = 5'h13;
  localparam logic [2:0] GRP [5] = '{3'h0, 3'h4, 3'h4, 3'h6, 3'h6};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] ev = 5'h00;
  logic mask_wr = 1'b0;
  logic [7:0] mask_wdata = 8'h00;
  logic [4:0] pend_clr = 5'h00;
  logic [1:0] overrun_clr = 2'h0;
  logic eob_wr = 1'b0;
  logic [1:0] eob_wdata = 2'h0;
  logic toggle_wr = 1'b0;
  logic [1:0] toggle_wdata = 2'h0;
  logic swap_enable = 1'b0;
  logic r2r = 1'b0;
  logic cp_bit1 = 1'b0;
  logic preset_load = 1'b0;
  logic [3:0] delay = 4'h0;
  logic end_block = 1'b1;
  logic dma_ack, dma_block_end, irq_req, dma_req, dma_chan, dma_second_byte, cnt_reset, out_a, out_b;
  logic [2:0] dma_priority;
  logic [7:0] irq_vector, cnt_addr, adr_addr, mask_rd;
  logic [4:0] pending;
  logic [1:0] flag_reg, eob_flags, swap_toggles;
  logic [1:0] tog = 2'h0;
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;
  int k;

  timer_irq_dma u_timer_irq_dma (.clk(clk), .rst_b(rst_b), .compare0_event(ev[4]), .compare1_event(ev[3]),
    .capture0_event(ev[2]), .capture1_event(ev[1]), .over_underflow_event(ev[0]), .vector_base_reg(VB),
    .mask_wr(mask_wr), .mask_wdata(mask_wdata), .pend_clr(pend_clr), .overrun_clr(overrun_clr),
    .eob_wr(eob_wr), .eob_wdata(eob_wdata), .toggle_wr(toggle_wr), .toggle_wdata(toggle_wdata),
    .swap_enable(swap_enable), .reg_to_reg_select(r2r), .counter_ptr_hi(CP), .counter_ptr_bit1(cp_bit1),
    .addr_ptr_hi(AP), .dma_ack(dma_ack), .dma_block_end(dma_block_end), .output_a_control(6'h30),
    .output_b_control(6'h09), .preset_load(preset_load), .preset_a(1'b0), .preset_b(1'b0),
    .irq_req(irq_req), .irq_vector(irq_vector), .dma_req(dma_req), .dma_chan(dma_chan),
    .dma_second_byte(dma_second_byte), .dma_priority(dma_priority), .dma_counter_ptr_addr(cnt_addr),
    .dma_addr_ptr_addr(adr_addr), .dma_counter_reset(cnt_reset), .irq_dma_mask_reg(mask_rd),
    .pending(pending), .flag_reg(flag_reg), .eob_flags(eob_flags), .swap_toggles(swap_toggles),
    .timer_output_a(out_a), .timer_output_b(out_b));

  dma_ctrl_model u_dma_ctrl_model (.clk(clk), .rst_b(rst_b), .dma_req(dma_req),
    .dma_second_byte(dma_second_byte), .delay(delay), .end_block(end_block), .dma_ack(dma_ack),
    .dma_block_end(dma_block_end));

  always #12.5 clk = ~clk;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      $display("unexpected at %0t: run did not finish", $time);
      tally_and_finish();
    end
  end

  task automatic chk_b(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_v(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic pulse_ev(input logic [4:0] v);
    @(negedge clk);
    ev = v;
    @(negedge clk);
    ev = 5'h00;
  endtask

  // kind 0 mask, 1 eob, 2 toggle, 3 pending clear, 4 overrun clear
  task automatic wr(input int kind, input logic [7:0] d);
    @(negedge clk);
    mask_wdata = d;
    eob_wdata = d[1:0];
    toggle_wdata = d[1:0];
    mask_wr = (kind == 0);
    eob_wr = (kind == 1);
    toggle_wr = (kind == 2);
    pend_clr = (kind == 3) ? d[4:0] : 5'h00;
    overrun_clr = (kind == 4) ? d[1:0] : 2'h0;
    @(negedge clk);
    mask_wr = 1'b0;
    eob_wr = 1'b0;
    toggle_wr = 1'b0;
    pend_clr = 5'h00;
    overrun_clr = 2'h0;
  endtask

  task automatic dma_word(input logic ch);
    logic [7:0] ca;
    logic [7:0] aa;
    k = 0;
    while (dma_req !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    ca = {CP, tog[ch], r2r ? cp_bit1 : ch, 1'b0};
    aa = r2r ? 8'h00 : {AP, tog[ch], ch, 1'b0};
    chk_b(dma_chan, ch, "dma channel");
    chk_v({5'h0, dma_priority}, ch ? 8'h06 : 8'h04, "first byte priority");
    chk_v(cnt_addr, ca, "counter pointer address");
    chk_v(adr_addr, aa, "address pointer address");
    while (dma_second_byte !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    chk_v({5'h0, dma_priority}, 8'h00, "second byte priority");
    chk_v(cnt_addr, ca | 8'h01, "second byte counter address");
    while (dma_req !== 1'b0 && k < 40) begin
      @(negedge clk);
      k++;
    end
    chk_b(cnt_reset, end_block, "counter reset");
    chk_b(eob_flags[ch], end_block, "end of block flag");
    if (end_block && swap_enable) tog[ch] = ~tog[ch];
    chk_v({6'h0, swap_toggles}, {6'h0, tog}, "swap toggles");
  endtask

  task automatic out_step(input logic [4:0] v, input logic [7:0] exp, input string what);
    pulse_ev(v);
    tick(1);
    chk_v({6'h0, out_a, out_b}, exp, what);
  endtask

  initial begin
    tick(2);
    rst_b = 1'b1;
    chk_v(mask_rd, 8'h00, "mask reset");
    chk_v({pending, 3'h0}, 8'h00, "pending reset");
    chk_v({flag_reg, eob_flags, swap_toggles, irq_req, dma_req}, 8'h00, "flags reset");
    for (int i = 0; i < 5; i++) begin
      wr(0, 8'h80 | (8'h01 << i));
      pulse_ev(5'h01 << i);
      tick(2);
      chk_b(irq_req, 1'b1, "irq raised");
      chk_v(irq_vector, {VB, GRP[i]}, "irq vector");
      wr(3, 8'h1f);
      tick(2);
      chk_b(irq_req, 1'b0, "irq after clear");
    end
    wr(0, 8'h11);
    pulse_ev(5'h11);
    tick(2);
    chk_b(irq_req, 1'b0, "global mask off");
    chk_v({3'h0, pending}, 8'h11, "pending kept while masked");
    wr(0, 8'h91);
    tick(2);
    chk_v(irq_vector, {VB, 3'h0}, "highest group wins");
    pulse_ev(5'h14);
    pulse_ev(5'h14);
    tick(1);
    chk_v({6'h0, flag_reg}, 8'h03, "overrun flags");
    wr(3, 8'h1f);
    wr(4, 8'h03);
    chk_v({1'b0, pending, flag_reg}, 8'h00, "flags cleared");
    swap_enable = 1'b1;
    wr(0, 8'hf4);
    pulse_ev(5'h14);
    dma_word(1'b0);
    dma_word(1'b1);
    chk_v({3'h0, pending}, 8'h14, "end of block pending");
    tick(2);
    chk_b(irq_req, 1'b1, "end of block irq");
    chk_v(irq_vector, {VB, 3'h4}, "end of block irq group");
    pulse_ev(5'h04);
    dma_word(1'b0);
    chk_v(mask_rd, 8'hd4, "protection clears dma mask");
    chk_v({6'h0, swap_toggles}, {6'h0, tog}, "toggle test");
    wr(1, 8'h00);
    wr(4, 8'h03);
    wr(3, 8'h14);
    wr(0, 8'hf4);
    chk_v({eob_flags, 1'b0, pending}, 8'h00, "routine done");
    chk_v(mask_rd, 8'hf4, "dma re-enabled");
    wr(1, 8'h01);
    tick(1);
    chk_v({eob_flags, 1'b0, pending}, 8'h44, "test write raises request");
    wr(1, 8'h00);
    wr(3, 8'h04);
    wr(2, 8'h02);
    tog = 2'h2;
    chk_v({6'h0, swap_toggles}, 8'h02, "toggle write");
    r2r = 1'b1;
    cp_bit1 = 1'b1;
    delay = 4'h3;
    end_block = 1'b0;
    pulse_ev(5'h14);
    dma_word(1'b0);
    dma_word(1'b1);
    chk_v({eob_flags, 1'b0, pending}, 8'h00, "no table end no request");
    wr(0, 8'h00);
    preset_load = 1'b1;
    tick(1);
    preset_load = 1'b0;
    tick(1);
    chk_v({6'h0, out_a, out_b}, 8'h00, "preset");
    out_step(5'h01, 8'h02, "over/underflow toggles a");
    out_step(5'h10, 8'h03, "compare 0 sets b");
    out_step(5'h08, 8'h02, "compare 1 clears b");
    out_step(5'h01, 8'h00, "toggle a back");
    tally_and_finish();
  end
endmodule
